// file: include/gpw_consts.svh
// Notes on behaviour
// - three 8-bit ports A, B, C give 24 lines, each input or output.
// - reading an input pin returns the live pin level of the read cycle.
// - written output data stays latched and drives pins until rewritten.
// - direction bit 1 makes the pin an input, 0 a CMOS output.
// - reading an output pin returns the latch, not the pin level.
// - pull-high bit 1 enables, and it only acts while the pin is input.
// - reset loads ones into data and direction, zeros into pull and wake.
// - in power down, a falling edge on a wake-enabled port A pin wakes.
// - misc bits 7..4 select open drain for port A bits 3..0.
// - misc bits 3..0 are watchdog storage resetting to 1,0,1,0.
// - divider output on A3, when optioned, drives only with direction output.
// - PWM on C4..C6 and A5 drives only with direction output.
// - an A pin selected as converter input loses its pull-high.
// - bit set or clear reads the whole port, changes one bit, writes back.
`ifndef GPW_CONSTS_SVH
`define GPW_CONSTS_SVH
`define GPW_NREGS       11
`define GPW_A_WAKE      4'h0
`define GPW_A_PA_DATA   4'h2
`define GPW_A_PB_DATA   4'h5
`define GPW_A_PC_DATA   4'h8
`define GPW_A_MISC      4'ha
`define GPW_RST_DATA    8'hff
`define GPW_RST_DIR     8'hff
`define GPW_RST_PULL    8'h00
`define GPW_RST_WAKE    8'h00
`define GPW_RST_MISC    8'h0a
`define GPW_OD_LSB      4
`define GPW_PFD_BIT     3
`define GPW_PWM_A_BIT   5
`endif

// file: include/gpw_pkg.sv
package gpw_pkg;
  typedef logic [7:0] gpw_byte_t;
  typedef enum {GPW_KIND_WAKE, GPW_KIND_PULL, GPW_KIND_DATA, GPW_KIND_DIR,
                GPW_KIND_MISC, GPW_KIND_NONE} gpw_kind_t;
endpackage

// file: core/gpw_pin_drv.sv
`timescale 1ns/1ps
module gpw_pin_drv #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] latch_in,
  input  wire logic [W-1:0] dir_in,
  input  wire logic [W-1:0] pull_in,
  input  wire logic [W-1:0] od_in,
  input  wire logic [W-1:0] alt_en_in,
  input  wire logic [W-1:0] alt_val_in,
  input  wire logic [W-1:0] analog_in,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe_out,
  output logic      [W-1:0] pull_out
);
  logic [W-1:0] val;
  always_comb
  begin
    val = (alt_en_in & alt_val_in) | (~alt_en_in & latch_in);
    pin_out    = val & ~od_in;
    pin_oe_out = ~dir_in & (~od_in | ~val);
    pull_out   = pull_in & dir_in & ~analog_in;
  end
endmodule // gpw_pin_drv

// file: core/gpw_wake.sv
`timescale 1ns/1ps
module gpw_wake (
  input  wire logic       clock_in,
  input  wire logic       resetn_in,
  input  wire logic [7:0] pin_in,
  input  wire logic [7:0] enable_in,
  input  wire logic       powered_down_in,
  output logic            wake_out
);
  logic [7:0] prev_reg;
  logic [7:0] prev_next;
  logic       wake_reg;
  logic       wake_next;
  always_comb
  begin
    prev_next = pin_in;
    wake_next = powered_down_in & |(enable_in & prev_reg & ~pin_in);
  end
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    // prev resets high so a pin already low at release is taken as an edge
    if (!resetn_in)
    begin
      prev_reg <= 8'hff;
      wake_reg <= 1'b0;
    end
    else
    begin
      prev_reg <= prev_next;
      wake_reg <= wake_next;
    end
  end
  assign wake_out = wake_reg;
  wake_edge_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (powered_down_in && |(enable_in & $past(pin_in) & ~pin_in)) |=> wake_out)
    else $error("wake missed on enabled falling edge");
endmodule // gpw_wake

// file: core/gpw_top.sv
`timescale 1ns/1ps
`include "gpw_consts.svh"
module gpw_top #(
  parameter bit PFD_OPTION = 1'b0
) (
  input  wire logic               clock_in,
  input  wire logic               resetn_in,
  input  wire logic [3:0]         mem_addr_in,
  input  wire logic               mem_wr_in,
  input  wire gpw_pkg::gpw_byte_t mem_wdata_in,
  input  wire logic               mem_rd_in,
  output gpw_pkg::gpw_byte_t      mem_rdata_out,
  input  wire logic               bit_op_in,
  input  wire logic               bit_set_in,
  input  wire logic [2:0]         bit_sel_in,
  input  wire gpw_pkg::gpw_byte_t pa_pin_in,
  output gpw_pkg::gpw_byte_t      pa_pin_out,
  output gpw_pkg::gpw_byte_t      pa_pin_oe_out,
  output gpw_pkg::gpw_byte_t      pa_pull_out,
  input  wire gpw_pkg::gpw_byte_t pb_pin_in,
  output gpw_pkg::gpw_byte_t      pb_pin_out,
  output gpw_pkg::gpw_byte_t      pb_pin_oe_out,
  output gpw_pkg::gpw_byte_t      pb_pull_out,
  input  wire gpw_pkg::gpw_byte_t pc_pin_in,
  output gpw_pkg::gpw_byte_t      pc_pin_out,
  output gpw_pkg::gpw_byte_t      pc_pin_oe_out,
  output gpw_pkg::gpw_byte_t      pc_pull_out,
  input  wire logic               powered_down_in,
  output logic                    wake_out,
  input  wire logic               freq_div_in,
  input  wire logic [3:0]         pwm_in,
  input  wire logic [3:0]         pwm_en_in,
  input  wire gpw_pkg::gpw_byte_t adc_sel_in,
  output logic [3:0]              watchdog_enable_field_out
);
  import gpw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  function automatic gpw_kind_t kind_of(input logic [3:0] a);
    if (a == `GPW_A_WAKE)
      return GPW_KIND_WAKE;
    else if (a == `GPW_A_MISC)
      return GPW_KIND_MISC;
    else if (a > `GPW_A_MISC)
      return GPW_KIND_NONE;
    else if (a % 3 == 1)
      return GPW_KIND_PULL;
    else if (a % 3 == 2)
      return GPW_KIND_DATA;
    else
      return GPW_KIND_DIR;
  endfunction

  function automatic gpw_byte_t rst_of(input logic [3:0] a);
    unique case (kind_of(a))
      GPW_KIND_WAKE: return `GPW_RST_WAKE;
      GPW_KIND_PULL: return `GPW_RST_PULL;
      GPW_KIND_DATA: return `GPW_RST_DATA;
      GPW_KIND_DIR:  return `GPW_RST_DIR;
      GPW_KIND_MISC: return `GPW_RST_MISC;
      GPW_KIND_NONE: return 8'h00;
    endcase
  endfunction

  function automatic gpw_byte_t mix_read(input gpw_byte_t latch, input gpw_byte_t dir,
                                         input gpw_byte_t pin);
    return (dir & pin) | (~dir & latch);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register file

  gpw_byte_t regs_reg  [`GPW_NREGS];
  gpw_byte_t regs_next [`GPW_NREGS];
  gpw_byte_t view      [`GPW_NREGS];
  gpw_byte_t pins      [3];
  gpw_byte_t rdata_reg;
  gpw_byte_t rdata_next;
  gpw_byte_t rmw_val;
  logic      addr_ok;
  logic [3:0] idx;

  assign pins[0] = pa_pin_in;
  assign pins[1] = pb_pin_in;
  assign pins[2] = pc_pin_in;
  assign idx     = mem_addr_in;
  assign addr_ok = kind_of(mem_addr_in) != GPW_KIND_NONE;

  always_comb
  begin
    for (int i = 0; i < `GPW_NREGS; i++)
    begin
      view[i] = regs_reg[i];
    end
    for (int p = 0; p < 3; p++)
    begin
      view[3*p+2] = mix_read(regs_reg[3*p+2], regs_reg[3*p+3], pins[p]);
    end
  end

  always_comb
  begin
    rmw_val = 8'h00;
    if (addr_ok)
    begin
      rmw_val = view[idx];
      rmw_val[bit_sel_in] = bit_set_in;
    end
  end

  always_comb
  begin
    for (int i = 0; i < `GPW_NREGS; i++)
    begin
      regs_next[i] = regs_reg[i];
    end
    if (mem_wr_in && addr_ok)
    begin
      regs_next[idx] = mem_wdata_in;
    end
    else if (bit_op_in && addr_ok)
    begin
      regs_next[idx] = rmw_val;
    end
    // unmapped reads return zero
    rdata_next = rdata_reg;
    if (mem_rd_in)
    begin
      rdata_next = addr_ok ? view[idx] : 8'h00;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      for (int i = 0; i < `GPW_NREGS; i++)
      begin
        regs_reg[i] <= rst_of(4'(i));
      end
      rdata_reg <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < `GPW_NREGS; i++)
      begin
        regs_reg[i] <= regs_next[i];
      end
      rdata_reg <= rdata_next;
    end
  end

  assign mem_rdata_out = rdata_reg;
  assign watchdog_enable_field_out = regs_reg[`GPW_A_MISC][3:0];

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers

  gpw_byte_t od    [3];
  gpw_byte_t alt_e [3];
  gpw_byte_t alt_v [3];
  gpw_byte_t ana   [3];
  gpw_byte_t p_out [3];
  gpw_byte_t p_oe  [3];
  gpw_byte_t p_pu  [3];

  always_comb
  begin
    for (int p = 0; p < 3; p++)
    begin
      od[p]    = 8'h00;
      alt_e[p] = 8'h00;
      alt_v[p] = 8'h00;
      ana[p]   = 8'h00;
    end
    od[0][3:0] = regs_reg[`GPW_A_MISC][`GPW_OD_LSB +: 4];
    alt_e[0][`GPW_PFD_BIT] = PFD_OPTION;
    alt_v[0][`GPW_PFD_BIT] = freq_div_in;
    alt_e[2][6:4] = pwm_en_in[2:0];
    alt_v[2][6:4] = pwm_in[2:0];
    alt_e[0][`GPW_PWM_A_BIT] = pwm_en_in[3];
    alt_v[0][`GPW_PWM_A_BIT] = pwm_in[3];
    ana[0] = adc_sel_in;
  end

  for (genvar p = 0; p < 3; p++)
  begin : g_port
    gpw_pin_drv #(
      .W (8)
    ) u_drv (
      .latch_in   (regs_reg[3*p+2]),
      .dir_in     (regs_reg[3*p+3]),
      .pull_in    (regs_reg[3*p+1]),
      .od_in      (od[p]),
      .alt_en_in  (alt_e[p]),
      .alt_val_in (alt_v[p]),
      .analog_in  (ana[p]),
      .pin_out    (p_out[p]),
      .pin_oe_out (p_oe[p]),
      .pull_out   (p_pu[p])
    );
  end

  assign pa_pin_out    = p_out[0];
  assign pa_pin_oe_out = p_oe[0];
  assign pa_pull_out   = p_pu[0];
  assign pb_pin_out    = p_out[1];
  assign pb_pin_oe_out = p_oe[1];
  assign pb_pull_out   = p_pu[1];
  assign pc_pin_out    = p_out[2];
  assign pc_pin_oe_out = p_oe[2];
  assign pc_pull_out   = p_pu[2];

  ////////////////////////////////////////////////////////////////////////////
  // wake-up

  gpw_wake u_wake (
    .clock_in        (clock_in),
    .resetn_in       (resetn_in),
    .pin_in          (pa_pin_in),
    .enable_in       (regs_reg[`GPW_A_WAKE]),
    .powered_down_in (powered_down_in),
    .wake_out        (wake_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  rd_live_pin_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (mem_rd_in && mem_addr_in == `GPW_A_PA_DATA && regs_reg[3] == 8'hff)
    |=> mem_rdata_out == $past(pa_pin_in))
    else $error("input read not live pin");

  latch_hold_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (!mem_wr_in && !bit_op_in) |=> regs_reg[`GPW_A_PB_DATA] == $past(regs_reg[5]))
    else $error("latch changed without write");

  dir_enable_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    pb_pin_oe_out == ~regs_reg[6] && (pb_pin_out & pb_pin_oe_out) == (regs_reg[5] & ~regs_reg[6]))
    else $error("port b drive mismatch");

  rd_latch_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (mem_rd_in && mem_addr_in == `GPW_A_PB_DATA && regs_reg[6] == 8'h00 && !mem_wr_in)
    ##1 1'b1 |-> mem_rdata_out == $past(regs_reg[5]))
    else $error("output read not latch");

  pull_gate_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    pc_pull_out == (regs_reg[7] & regs_reg[9]))
    else $error("pull not gated by direction");

  reset_vals_a: assert property (
    @(posedge clock_in)
    $rose(resetn_in) |-> regs_reg[2] == 8'hff && regs_reg[3] == 8'hff && regs_reg[0] == 8'h00
      && watchdog_enable_field_out == 4'ha)
    else $error("reset values wrong");

  od_drive_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (regs_reg[10][4] && !regs_reg[3][0])
    |-> pa_pin_out[0] == 1'b0 && pa_pin_oe_out[0] == !regs_reg[2][0])
    else $error("open drain drive wrong");

  pfd_gate_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (PFD_OPTION && !regs_reg[3][3] && !regs_reg[10][7]) |-> pa_pin_out[3] == freq_div_in)
    else $error("divider output not on pin");

  pwm_gate_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    regs_reg[9][4] |-> !pc_pin_oe_out[4])
    else $error("pwm drives an input pin");

  adc_pull_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (adc_sel_in & pa_pull_out) == 8'h00)
    else $error("pull left on analog pin");

  bit_rmw_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (bit_op_in && !mem_wr_in && addr_ok) |=> regs_reg[$past(idx)] == $past(rmw_val)
      && regs_reg[$past(idx)][$past(bit_sel_in)] == $past(bit_set_in))
    else $error("bit operation result wrong");
endmodule // gpw_top

// file: bench/gpw_pins_model.sv
`timescale 1ns/1ps
module gpw_pins_model (
  input  wire logic       clock_in,
  input  wire logic [7:0] drv_in,
  input  wire logic [7:0] oe_in,
  input  wire logic [7:0] pull_in,
  input  wire logic [7:0] sw_in,
  input  wire logic [7:0] sw_en_in,
  output logic      [7:0] level_out
);
  logic [7:0] noise_reg = 8'h5a;
  ////////////////////////////////////////////////////////////
  // unheld pins wander, so a stale value never reads as good
  always @(posedge clock_in) noise_reg <= #1 ~noise_reg;
  ////////////////////////////////////////////////////////////
  // released pin follows switches
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      level_out[i] = oe_in[i] ? drv_in[i] : sw_en_in[i] ? sw_in[i] :
                     pull_in[i] ? 1'b1 : noise_reg[i];
  end
endmodule // gpw_pins_model

// file: bench/tb.sv
`timescale 1ns/1ps
`include "gpw_consts.svh"
module tb;
  import gpw_pkg::*;
  logic       clock_in = 1'b0;
  logic       resetn_in = 1'b0;
  logic [3:0] addr = 4'h0;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       bop = 1'b0;
  logic       bset = 1'b0;
  logic [2:0] bsel = 3'h0;
  logic       pd = 1'b0;
  logic       fd = 1'b0;
  logic       wake;
  logic [3:0] wdf;
  logic [3:0] pwm = 4'h0;
  logic [3:0] pwm_en = 4'h0;
  gpw_byte_t  wdata = 8'h00;
  gpw_byte_t  adc = 8'h00;
  gpw_byte_t  rdata;
  gpw_byte_t  lvl [3];
  gpw_byte_t  out [3];
  gpw_byte_t  oe [3];
  gpw_byte_t  pul [3];
  gpw_byte_t  sw [3] = '{8'hff, 8'hff, 8'hff};
  gpw_byte_t  swe [3] = '{8'hff, 8'hff, 8'hff};
  gpw_byte_t  shd [11];
  int         n_mismatch = 0;
  int         tests_run = 0;
  int         a;
  gpw_byte_t  k;
  ////////////////////////////////////////////////////////////
  always #25 clock_in = ~clock_in;
  gpw_top #(.PFD_OPTION(1'b1)) i_dut (
    .clock_in(clock_in), .resetn_in(resetn_in), .mem_addr_in(addr), .mem_wr_in(wr),
    .mem_wdata_in(wdata), .mem_rd_in(rd), .mem_rdata_out(rdata), .bit_op_in(bop),
    .bit_set_in(bset), .bit_sel_in(bsel), .pa_pin_in(lvl[0]), .pa_pin_out(out[0]),
    .pa_pin_oe_out(oe[0]), .pa_pull_out(pul[0]), .pb_pin_in(lvl[1]), .pb_pin_out(out[1]),
    .pb_pin_oe_out(oe[1]), .pb_pull_out(pul[1]), .pc_pin_in(lvl[2]), .pc_pin_out(out[2]),
    .pc_pin_oe_out(oe[2]), .pc_pull_out(pul[2]), .powered_down_in(pd), .wake_out(wake),
    .freq_div_in(fd), .pwm_in(pwm), .pwm_en_in(pwm_en), .adc_sel_in(adc),
    .watchdog_enable_field_out(wdf));
  for (genvar p = 0; p < 3; p++)
  begin : g_pins
    gpw_pins_model i_pm (.clock_in(clock_in), .drv_in(out[p]), .oe_in(oe[p]),
      .pull_in(pul[p]), .sw_in(sw[p]), .sw_en_in(swe[p]), .level_out(lvl[p]));
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(gpw_byte_t seen, gpw_byte_t exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  // input bits read the pins, output bits the latch
  function automatic gpw_byte_t view(int r);
    if (r > 10)
      return 8'h00;
    if (r % 3 == 2 && r < 9)
      return (sw[r / 3] & shd[r + 1]) | (shd[r] & ~shd[r + 1]);
    return shd[r];
  endfunction
  task automatic wr_reg(int r, gpw_byte_t d);
    addr = r[3:0];
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
    if (r < 11)
      shd[r] = d;
  endtask
  task automatic rd_reg(int r);
    addr = r[3:0];
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    cyc(1);
  endtask
  task automatic chk_rd(int r);
    rd_reg(r);
    chk(rdata, view(r));
  endtask
  task automatic bit_op(int r, int s, bit st);
    gpw_byte_t v;
    v = view(r);
    v[s] = st;
    addr = r[3:0];
    bsel = s[2:0];
    bset = st;
    bop = 1'b1;
    cyc(1);
    bop = 1'b0;
    cyc(1);
    shd[r] = v;
  endtask
  task automatic pin_chk();
    gpw_byte_t d, e, od, x;
    for (int p = 0; p < 3; p++)
    begin
      d = ~shd[3 * p + 3];
      e = shd[3 * p + 2];
      od = (p == 0) ? {4'h0, shd[10][7:4]} : 8'h00;
      // divider and open drain together on bit 3 left open
      x = od & 8'h08;
      if (p == 0)
        e[5] = pwm_en[3] ? pwm[3] : e[5];
      for (int i = 0; i < 3; i++)
        if (p == 2 && pwm_en[i])
          e[4 + i] = pwm[i];
      chk(oe[p] & ~x, d & ~(od & e) & ~x);
      chk(out[p] & od & d & ~x, 8'h00);
      if (p == 0)
        e[3] = fd;
      chk(out[p] & d & ~od, e & d & ~od);
      chk(pul[p], shd[3 * p + 1] & ~d & ((p == 0) ? ~adc : 8'hff));
    end
    chk({4'h0, wdf}, {4'h0, shd[10][3:0]});
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    #5_000_000;
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    k = 8'($urandom(10));
    cyc(8);
    resetn_in = 1'b1;
    for (int r = 0; r < 11; r++)
      shd[r] = (r == 10) ? `GPW_RST_MISC : (r == 0) ? `GPW_RST_WAKE :
               (r % 3 == 1) ? `GPW_RST_PULL : (r % 3 == 2) ? `GPW_RST_DATA : `GPW_RST_DIR;
    for (int r = 0; r < 16; r++)
      chk_rd(r);
    chk(oe[0] | oe[1] | oe[2] | pul[0], 8'h00);
    repeat (30)
    begin
      for (int p = 0; p < 3; p++)
      begin
        sw[p] = 8'($urandom);
        for (int r = 1; r < 4; r++)
          wr_reg(3 * p + r, 8'($urandom));
      end
      wr_reg(10, 8'($urandom));
      wr_reg(11 + $urandom % 5, 8'($urandom));
      adc = 8'($urandom);
      pwm = 4'($urandom);
      pwm_en = 4'($urandom);
      fd = 1'($urandom);
      #1;
      pin_chk();
      for (int r = 0; r < 16; r++)
        chk_rd(r);
    end
    k = 8'($urandom);
    wr_reg(6, 8'hff);
    wr_reg(4, k);
    swe[1] = 8'h00;
    rd_reg(5);
    chk(rdata & k, k);
    swe[1] = 8'hff;
    repeat (16)
    begin
      a = $urandom % 11;
      if (a % 3 == 2 && a < 9)
        wr_reg(a + 1, 8'($urandom));
      bit_op(a, $urandom % 8, 1'($urandom));
      if (a % 3 == 2 && a < 9)
        wr_reg(a + 1, 8'h00);
      chk_rd(a);
    end
    wr_reg(3, 8'hff);
    sw[0] = 8'hff;
    for (int i = 0; i < 12; i++)
    begin
      k = 8'($urandom);
      wr_reg(0, k);
      pd = (i > 3);
      sw[0][i % 8] = 1'b0;
      cyc(1);
      chk({7'h0, wake}, {7'h0, k[i % 8] & pd});
      sw[0][i % 8] = 1'b1;
      cyc(1);
      chk({7'h0, wake}, 8'h00);
    end
    end_of_test();
  end
endmodule // tb
